// file: rtl/smrc_regs.sv
`timescale 1ns/1ps
`default_nettype none

// Function
// - if code scaled, subtracted, drives mixer
// - if code resets fifteen, receive only
// - signed offset trim added to word
// - top two carrier bits read zero
// - carrier word built from three bytes
// - bandwidth exponent and mantissa set decimation
// - rate mantissa nine bits, hidden one
// - rate uses 256 plus mantissa, exponent
// - rate exponent low nibble, resets twelve
// - rate mantissa own register, resets 0x22
module smrc_regs
    import smrc_pkg::*;
#(
    parameter int ADDR_W = 6
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic rx_active,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic [23:0] synth_word,
    output logic [4:0] if_mixer_code,
    output logic if_spare,
    output logic [1:0] bandwidth_exponent,
    output logic [1:0] bandwidth_mantissa,
    output logic [6:0] bw_divider,
    output logic [3:0] symbol_rate_exponent,
    output logic [8:0] rate_mantissa_full,
    output smrc_cfg_t cfg
);

    // elaboration check: the highest mapped offset needs five address bits
    if (ADDR_W < 5) begin : g_addr_w_check
        $error("smrc_regs: ADDR_W too small for 0x11");
    end

    // storage, one flip-flop group per register field
    logic [4:0] if_code_reg;
    logic if_spare_reg;
    logic [7:0] synth_offset_value_reg;
    logic [5:0] word_hi_reg;
    logic [7:0] word_mid_reg;
    logic [7:0] word_lo_reg;
    logic [1:0] bw_e_reg;
    logic [1:0] bw_m_reg;
    logic [3:0] rate_e_reg;
    logic [7:0] rate_m_reg;
    logic [7:0] rd_data_reg;
    logic rd_valid_reg;
    logic [23:0] synth_word_reg;
    logic [4:0] mixer_code_reg;
    logic [6:0] bw_div_reg;
    logic [8:0] rate_full_reg;

    // address match shared by write and read decode
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [5:0] target);
        hit = (a == ADDR_W'(target));
    endfunction

    wire logic sel_if = hit(addr, SMRC_ADDR_IF_CODE);
    wire logic sel_off = hit(addr, SMRC_ADDR_OFFSET);
    wire logic sel_hi = hit(addr, SMRC_ADDR_WORD_HI);
    wire logic sel_mid = hit(addr, SMRC_ADDR_WORD_MID);
    wire logic sel_lo = hit(addr, SMRC_ADDR_WORD_LO);
    wire logic sel_bw = hit(addr, SMRC_ADDR_BW_EXP);
    wire logic sel_mant = hit(addr, SMRC_ADDR_MANT);

    // carrier word and signed trim; trim is sign-extended to 24 bits
    wire logic [23:0] carrier_base_word =
        {2'h0, word_hi_reg, word_mid_reg, word_lo_reg};
    wire logic [23:0] offset_ext =
        {{16{synth_offset_value_reg[7]}}, synth_offset_value_reg};
    // base word in 1/2^16 steps, trim in 1/2^14: trim shifted up by two
    wire logic [23:0] offset_scaled = {offset_ext[21:0], 2'h0};
    wire logic [23:0] word_trimmed =
        carrier_base_word + offset_scaled;
    // if code in 1/2^10 steps is 64 word steps
    wire logic [23:0] if_in_word = {13'h0, if_code_reg, 6'h0};
    wire logic [23:0] word_next = rx_active ?
        word_trimmed - if_in_word : word_trimmed;
    wire logic [4:0] mixer_next = rx_active ? if_code_reg : 5'h00;

    // bandwidth divider 8*(4+m); the exponent stays a shift downstream
    wire logic [6:0] bw_div_next =
        {1'h0, 3'(SMRC_BW_BASE + {1'h0, bw_m_reg}), 3'h0};
    // rate mantissa with hidden leading one restored
    wire logic [8:0] rate_full_next =
        9'(SMRC_HIDDEN_ONE + {2'h0, rate_m_reg});

    // read mux; unused bits and unmapped addresses read zero
    wire logic [7:0] rd_mux =
        sel_if ? {2'h0, if_spare_reg, if_code_reg} :
        sel_off ? synth_offset_value_reg :
        sel_hi ? {2'h0, word_hi_reg} :
        sel_mid ? word_mid_reg :
        sel_lo ? word_lo_reg :
        sel_bw ? {bw_e_reg, bw_m_reg, rate_e_reg} :
        sel_mant ? rate_m_reg : 8'h00;

    // register writes; bits 7:6 of two registers are never stored
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            if_code_reg <= SMRC_RST_IF_CODE;
            if_spare_reg <= SMRC_RST_IF_SPARE;
            synth_offset_value_reg <= SMRC_RST_OFFSET;
            word_hi_reg <= SMRC_RST_WORD_HI;
            word_mid_reg <= SMRC_RST_WORD_MID;
            word_lo_reg <= SMRC_RST_WORD_LO;
            bw_e_reg <= SMRC_RST_BW_E;
            bw_m_reg <= SMRC_RST_BW_M;
            rate_e_reg <= SMRC_RST_RATE_E;
            rate_m_reg <= SMRC_RST_RATE_M;
        end else if (wr_en) begin
            if (sel_if) begin
                if_code_reg <= wr_data[SMRC_IF_CODE_LSB +: 5];
                if_spare_reg <= wr_data[SMRC_IF_SPARE_BIT];
            end
            if (sel_off) begin
                synth_offset_value_reg <= wr_data;
            end
            if (sel_hi) begin
                word_hi_reg <= wr_data[5:0];
            end
            if (sel_mid) begin
                word_mid_reg <= wr_data;
            end
            if (sel_lo) begin
                word_lo_reg <= wr_data;
            end
            if (sel_bw) begin
                bw_e_reg <= wr_data[SMRC_BW_E_LSB +: 2];
                bw_m_reg <= wr_data[SMRC_BW_M_LSB +: 2];
                rate_e_reg <= wr_data[SMRC_RATE_E_LSB +: 4];
            end
            if (sel_mant) begin
                rate_m_reg <= wr_data;
            end
        end
    end

    // read data registered: answers one cycle after rd_en
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rd_data_reg <= 8'h00;
            rd_valid_reg <= 1'h0;
        end else begin
            rd_data_reg <= rd_en ? rd_mux : 8'h00;
            rd_valid_reg <= rd_en;
        end
    end

    // derived outputs registered so every output leaves a flip-flop;
    // a write shows on them one cycle after it is stored
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            synth_word_reg <= 24'h000000;
            mixer_code_reg <= 5'h00;
            bw_div_reg <= 7'h00;
            rate_full_reg <= 9'h000;
        end else begin
            synth_word_reg <= word_next;
            mixer_code_reg <= mixer_next;
            bw_div_reg <= bw_div_next;
            rate_full_reg <= rate_full_next;
        end
    end

    assign rd_data = rd_data_reg;
    assign rd_valid = rd_valid_reg;
    assign synth_word = synth_word_reg;
    assign if_mixer_code = mixer_code_reg;
    assign if_spare = if_spare_reg;
    assign bandwidth_exponent = bw_e_reg;
    assign bandwidth_mantissa = bw_m_reg;
    assign bw_divider = bw_div_reg;
    assign symbol_rate_exponent = rate_e_reg;
    assign rate_mantissa_full = rate_full_reg;

    // bundled copy for downstream blocks
    assign cfg.synth_word = synth_word_reg;
    assign cfg.if_mixer_code = mixer_code_reg;
    assign cfg.bandwidth_exponent = bw_e_reg;
    assign cfg.bandwidth_mantissa = bw_m_reg;
    assign cfg.symbol_rate_exponent = rate_e_reg;
    assign cfg.symbol_rate_mantissa = rate_m_reg;
    assign cfg.rate_mantissa_full = rate_full_reg;
    assign cfg.bw_divider = bw_div_reg;

endmodule

`default_nettype wire

// file: rtl/smrc_pkg.sv
package smrc_pkg;
    // register addresses
    localparam logic [5:0] SMRC_ADDR_IF_CODE = 6'h0B;
    localparam logic [5:0] SMRC_ADDR_OFFSET = 6'h0C;
    localparam logic [5:0] SMRC_ADDR_WORD_HI = 6'h0D;
    localparam logic [5:0] SMRC_ADDR_WORD_MID = 6'h0E;
    localparam logic [5:0] SMRC_ADDR_WORD_LO = 6'h0F;
    localparam logic [5:0] SMRC_ADDR_BW_EXP = 6'h10;
    localparam logic [5:0] SMRC_ADDR_MANT = 6'h11;
    // reset values
    localparam logic [4:0] SMRC_RST_IF_CODE = 5'h0F;
    localparam logic [0:0] SMRC_RST_IF_SPARE = 1'h0;
    localparam logic [7:0] SMRC_RST_OFFSET = 8'h00;
    localparam logic [5:0] SMRC_RST_WORD_HI = 6'h1E;
    localparam logic [7:0] SMRC_RST_WORD_MID = 8'hC4;
    localparam logic [7:0] SMRC_RST_WORD_LO = 8'hEC;
    localparam logic [1:0] SMRC_RST_BW_E = 2'h2;
    localparam logic [1:0] SMRC_RST_BW_M = 2'h0;
    localparam logic [3:0] SMRC_RST_RATE_E = 4'hC;
    localparam logic [7:0] SMRC_RST_RATE_M = 8'h22;
    // field positions
    localparam int SMRC_IF_CODE_LSB = 0;
    localparam int SMRC_IF_SPARE_BIT = 5;
    localparam int SMRC_BW_E_LSB = 6;
    localparam int SMRC_BW_M_LSB = 4;
    localparam int SMRC_RATE_E_LSB = 0;
    // fixed scale points of the derived quantities
    localparam logic [9:0] SMRC_HIDDEN_ONE = 10'h100;
    localparam logic [2:0] SMRC_BW_BASE = 3'h4;

    // configuration handed to synthesizer and demodulator
    typedef struct packed {
        logic [23:0] synth_word;
        logic [4:0] if_mixer_code;
        logic [1:0] bandwidth_exponent;
        logic [1:0] bandwidth_mantissa;
        logic [3:0] symbol_rate_exponent;
        logic [7:0] symbol_rate_mantissa;
        logic [8:0] rate_mantissa_full;
        logic [6:0] bw_divider;
    } smrc_cfg_t;
endpackage

// file: tb/smrc_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module smrc_regs_monitor
    import smrc_pkg::*;
#(
    parameter int ADDR_W = 6
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic rx_active,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    input wire logic [23:0] synth_word,
    input wire logic [4:0] if_mixer_code,
    input wire logic [1:0] bandwidth_mantissa,
    input wire logic [6:0] bw_divider,
    input wire logic [3:0] symbol_rate_exponent,
    input wire logic [8:0] rate_mantissa_full,
    input wire smrc_cfg_t cfg
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // reads answer one cycle later; holes answer zero
    property p_unmapped;
        rd_en && (addr < 6'h0B || addr > 6'h11) |=> rd_valid && rd_data == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_hi; rd_en && addr == 6'h0D |=> rd_data[7:6] == 2'h0; endproperty
    a_hi: assert property (p_hi)
        else $error("carrier high byte top bits set");
    property p_exp;
        rd_en && addr == 6'h10 |=> rd_data[3:0] == $past(symbol_rate_exponent);
    endproperty
    a_exp: assert property (p_exp)
        else $error("rate exponent not in low nibble");
    // derived values lag the stored fields by one cycle
    property p_mant;
        !$past(reset) |->
        rate_mantissa_full == 9'h100 + $past(cfg.symbol_rate_mantissa);
    endproperty
    a_mant: assert property (p_mant)
        else $error("hidden one missing from mantissa");
    property p_bw;
        !$past(reset) |->
        bw_divider == 7'h08 * (7'h04 + $past(bandwidth_mantissa));
    endproperty
    a_bw: assert property (p_bw)
        else $error("bandwidth divider wrong");
    property p_off; !$past(rx_active) |-> if_mixer_code == 5'h00; endproperty
    a_off: assert property (p_off)
        else $error("mixer code live outside receive");
    property p_mix;
        rd_en && addr == 6'h0B && rx_active |=> if_mixer_code == rd_data[4:0];
    endproperty
    a_mix: assert property (p_mix)
        else $error("mixer code differs from stored code");
    // entering receive pulls the word down by the scaled code
    property p_synth;
        !$past(reset) && !$past(rx_active) && rx_active && !$past(wr_en)
        |=> synth_word == $past(synth_word) - {13'h0, if_mixer_code, 6'h00};
    endproperty
    a_synth: assert property (p_synth)
        else $error("receive offset not subtracted");
    c_rd: cover property (rd_valid);
    c_rx: cover property ($rose(rx_active));
    c_wr: cover property (wr_en ##1 rd_en);
endmodule
bind smrc_regs smrc_regs_monitor #(.ADDR_W(ADDR_W)) smrc_regs_monitor_inst (
    .clk(clk), .reset(reset), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .rx_active(rx_active), .rd_data(rd_data), .rd_valid(rd_valid),
    .synth_word(synth_word), .if_mixer_code(if_mixer_code),
    .bandwidth_mantissa(bandwidth_mantissa), .bw_divider(bw_divider),
    .symbol_rate_exponent(symbol_rate_exponent),
    .rate_mantissa_full(rate_mantissa_full), .cfg(cfg));
`default_nettype wire

// file: tb/test_synth_and_modem_rate_config.sv
`timescale 1ns/1ps
`default_nettype none
module test_synth_and_modem_rate_config import smrc_pkg::*;;
    logic clk = 1'b0, reset = 1'b1, wr_en = 1'b0, rd_en = 1'b0, rx_active = 1'b0;
    logic [5:0] addr = 6'h00;
    logic [7:0] wr_data = 8'h00, rd_data;
    logic rd_valid, if_spare;
    logic [1:0] bw_e, bw_m;
    logic [3:0] rate_e;
    logic [4:0] if_mixer_code;
    logic [6:0] bw_divider;
    logic [8:0] rate_full;
    logic [23:0] synth_word;
    smrc_cfg_t cfg;
    int fails = 0, total_checks = 0;
    always #2.5 clk = ~clk;
    smrc_regs smrc_regs_inst (.clk(clk), .reset(reset), .wr_en(wr_en),
        .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .rx_active(rx_active),
        .rd_data(rd_data), .rd_valid(rd_valid), .synth_word(synth_word),
        .if_mixer_code(if_mixer_code), .if_spare(if_spare),
        .bandwidth_exponent(bw_e), .bandwidth_mantissa(bw_m),
        .bw_divider(bw_divider), .symbol_rate_exponent(rate_e),
        .rate_mantissa_full(rate_full), .cfg(cfg));
    task automatic check(string name, logic [23:0] exp, logic [23:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // inputs move on the falling edge, away from sampling
    task automatic wr(logic [5:0] a, logic [7:0] d);
        @(negedge clk);
        wr_en = 1'b1;
        addr = a;
        wr_data = d;
        @(negedge clk);
        wr_en = 1'b0;
    endtask
    task automatic rd(logic [5:0] a, logic [7:0] exp);
        @(negedge clk);
        rd_en = 1'b1;
        addr = a;
        @(negedge clk);
        rd_en = 1'b0;
        check("rd_valid", 24'h1, {23'h0, rd_valid});
        check("rd_data", {16'h0, exp}, {16'h0, rd_data});
    endtask
    task automatic t_reset_values();
        logic [7:0] rv [7] = '{8'h0F, 8'h00, 8'h1E, 8'hC4, 8'hEC, 8'h8C, 8'h22};
        for (int i = 0; i < 7; i++) rd(6'h0B + 6'(i), rv[i]);
        check("synth_word", 24'h1EC4EC, synth_word);
        check("rate_full", 24'h122, {15'h0, rate_full});
        check("bw_divider", 24'h20, {17'h0, bw_divider});
        check("if_mixer_code", 24'h0, {19'h0, if_mixer_code});
    endtask
    // negative trim, then the receive subtraction on top of it
    task automatic t_carrier();
        wr(6'h0B, 8'hFF);
        rd(6'h0B, 8'h3F);
        check("if_spare", 24'h1, {23'h0, if_spare});
        wr(6'h0D, 8'hFF);
        rd(6'h0D, 8'h3F);
        wr(6'h0D, 8'h0A);
        wr(6'h0E, 8'h12);
        wr(6'h0F, 8'h34);
        wr(6'h0C, 8'hFF);
        wr(6'h0B, 8'h01);
        @(negedge clk);
        check("synth_word", 24'h0A1230, synth_word);
        rx_active = 1'b1;
        @(negedge clk);
        check("synth_word", 24'h0A11F0, synth_word);
        check("if_mixer_code", 24'h1, {19'h0, if_mixer_code});
        rd(6'h0B, 8'h01);
        rx_active = 1'b0;
    endtask
    task automatic t_modem();
        wr(6'h10, 8'hF5);
        wr(6'h11, 8'hFF);
        @(negedge clk);
        check("bw_divider", 24'h38, {17'h0, bw_divider});
        check("rate_full", 24'h1FF, {15'h0, rate_full});
        check("rate_e", 24'h5, {20'h0, rate_e});
        check("bw_e", 24'h3, {22'h0, bw_e});
        check("bw_m", 24'h3, {22'h0, bw_m});
        check("cfg_mant", 24'hFF, {16'h0, cfg.symbol_rate_mantissa});
        check("cfg_word", 24'h0A1230, cfg.synth_word);
        check("cfg_bw_div", 24'h38, {17'h0, cfg.bw_divider});
        rd(6'h10, 8'hF5);
        wr(6'h12, 8'h55);
        rd(6'h12, 8'h00);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge clk);
        reset = 1'b0;
        t_reset_values();
        t_carrier();
        t_modem();
        report_and_stop();
    end
endmodule
`default_nettype wire
